// file: design/crf_pkg.sv
// Shared constants and types of the core register file
package crf_pkg;
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SP = 4'h1;
    localparam logic [3:0] REG_SR = 4'h2;
    localparam logic [3:0] REG_CG = 4'h3;
    // Flag bit positions inside the flags register
    localparam int unsigned SR_C = 0;
    localparam int unsigned SR_Z = 1;
    localparam int unsigned SR_N = 2;
    localparam int unsigned SR_GIE = 3;
    localparam int unsigned SR_HALT = 4;
    localparam int unsigned SR_XTAL = 5;
    localparam int unsigned SR_LOOP = 6;
    localparam int unsigned SR_DCO = 7;
    localparam int unsigned SR_V = 8;
    localparam logic [19:0] PC_RESET = 20'h0_0000;
    localparam logic [19:0] SP_RESET = 20'h0_0000;
    localparam logic [15:0] SR_RESET = 16'h0000;
    localparam logic [19:0] GPR_RESET = 20'h0_0000;
    localparam logic [19:0] CONST_0 = 20'h0_0000;
    localparam logic [19:0] CONST_1 = 20'h0_0001;
    localparam logic [19:0] CONST_2 = 20'h0_0002;
    localparam logic [19:0] CONST_4 = 20'h0_0004;
    localparam logic [19:0] CONST_8 = 20'h0_0008;
    localparam logic [19:0] CONST_ONES = 20'hF_FFFF;
    localparam logic [19:0] VEC_TOP = 20'h0_FFFE;
    localparam logic [19:0] STEP_WORD = 20'h0_0002;
    localparam logic [19:0] STEP_ADDR = 20'h0_0004;
    localparam logic [3:0] ADV_BASE = 4'h2;
    // Software port map
    localparam logic [3:0] BUS_PC = 4'h0;
    localparam logic [3:0] BUS_SP = 4'h1;
    localparam logic [3:0] BUS_SR = 4'h2;
    localparam logic [3:0] BUS_STAT = 4'h3;
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_HALT = 1;
    localparam int unsigned STAT_IRQ = 2;
    typedef enum logic [1:0] {CRF_BYTE, CRF_WORD, CRF_ADDR} crf_width_t;
    typedef enum logic [3:0] {
        CRF_NOP, CRF_ADVANCE, CRF_JUMP16, CRF_JUMP20, CRF_CALL16, CRF_CALL20,
        CRF_EXIT16, CRF_EXIT20, CRF_IRQ, CRF_IEXIT, CRF_PUSH, CRF_POP,
        CRF_WRITE, CRF_SIGN_WIDEN
    } crf_op_t;
    typedef enum logic {CRF_IDLE, CRF_IRQ_SR} crf_state_t;
endpackage

// file: design/crf_mem_if.sv
// Port bundle between the control logic and the working register array
`timescale 1ns/10ps
`default_nettype none
interface crf_mem_if;
    logic we;
    logic [3:0] waddr;
    logic [19:0] wdata;
    logic [3:0] raddr;
    logic [19:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// file: design/crf_mem.sv
// Working register array with registered read data
`timescale 1ns/10ps
`default_nettype none
module crf_mem
    import crf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    crf_mem_if.mem port
);
    typedef struct packed {
        logic [15:0][19:0] regs;
        logic [19:0] rdata;
    } crf_mem_state_t;

    crf_mem_state_t st;
    crf_mem_state_t nx;

    // A read in the cycle of a write to the same entry returns the old value
    always_comb begin
        nx = st;
        nx.rdata = st.regs[port.raddr];
        if (port.we) begin
            nx.regs[port.waddr] = port.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            for (int i = 0; i < 16; i++) begin
                st.regs[i] <= GPR_RESET;
            end
        end else begin
            st <= nx;
        end
    end

    assign port.rdata = st.rdata;
endmodule
`default_nettype wire

// file: design/crf_core.sv
// Core register file: counter, stack, flags, constants and working registers
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module crf_core
    import crf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire crf_op_t cmd_op,
    input wire crf_width_t cmd_width,
    input wire logic [3:0] cmd_dst,
    input wire logic [1:0] cmd_len,
    input wire logic [19:0] cmd_data,
    input wire logic [15:0] cmd_aux,
    input wire logic alu_en,
    input wire logic alu_sub,
    input wire crf_width_t alu_width,
    input wire logic [19:0] alu_a,
    input wire logic [19:0] alu_b,
    input wire logic [19:0] alu_res,
    input wire logic alu_carry,
    input wire logic src_rd,
    input wire logic [3:0] src_reg,
    input wire logic [1:0] source_mode_field,
    input wire crf_width_t src_width,
    input wire logic irq_req,
    input wire logic [5:0] irq_line,
    input wire logic crystal_in_use,
    input wire logic dco_in_use,
    input wire logic [3:0] bus_addr,
    input wire logic [19:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [19:0] bus_rdata,
    output logic [19:0] pc_out,
    output logic [19:0] sp_out,
    output logic [15:0] flags_register,
    output logic busy,
    output logic [19:0] operand,
    output logic operand_valid,
    output logic operand_const,
    output logic operand_illegal,
    output logic push_valid,
    output logic [19:0] push_addr,
    output logic [19:0] push_data,
    output logic push_wide,
    output logic irq_accept,
    output logic [19:0] vec_addr,
    output logic core_halt,
    output logic loop_control_disable,
    output logic crystal_disable,
    output logic digital_oscillator_disable
);
    typedef struct packed {
        logic [19:0] pc;
        logic [19:0] sp;
        logic [15:0] sr;
        crf_state_t state;
        logic busy;
        logic [19:0] irq_pc;
        logic [19:0] irq_vec;
        logic s1_valid;
        logic [3:0] s1_reg;
        logic [1:0] s1_mode;
        crf_width_t s1_width;
        logic [19:0] operand;
        logic operand_valid;
        logic operand_const;
        logic operand_illegal;
        logic push_valid;
        logic [19:0] push_addr;
        logic [19:0] push_data;
        logic push_wide;
        logic irq_accept;
        logic [19:0] vec_addr;
        logic [19:0] bus_rdata;
        logic core_halt;
        logic loop_off;
        logic crystal_off;
        logic dco_off;
    } crf_core_state_t;

    function automatic logic [19:0] width_clear(crf_width_t w, logic [19:0] d);
        case (w)
            CRF_BYTE: width_clear = {12'h000, d[7:0]};
            CRF_WORD: width_clear = {4'h0, d[15:0]};
            default: width_clear = d;
        endcase
    endfunction

    function automatic logic msb_of(crf_width_t w, logic [19:0] d);
        case (w)
            CRF_BYTE: msb_of = d[7];
            CRF_WORD: msb_of = d[15];
            default: msb_of = d[19];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_pipe;
    logic rst_n;

    // Release of the asynchronous reset is retimed to the clock
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    crf_mem_if mem_if ();

    crf_mem u_mem (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .port(mem_if.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    crf_core_state_t st;
    crf_core_state_t nx;
    logic take;
    logic do_write;
    logic [19:0] dst_val;
    logic [19:0] stack_step;
    logic [19:0] opv;
    logic [3:0] adv;
    logic sa;
    logic sb;
    logic sres;

    always_comb begin
        nx = st;
        do_write = 1'b0;
        dst_val = width_clear(cmd_width, cmd_data);
        stack_step = (cmd_width == CRF_ADDR) ? STEP_ADDR : STEP_WORD;
        adv = {1'b0, cmd_len, 1'b0} + ADV_BASE;
        opv = mem_if.rdata;
        sa = msb_of(alu_width, alu_a);
        sb = msb_of(alu_width, alu_b);
        sres = msb_of(alu_width, alu_res);
        nx.push_valid = 1'b0;
        nx.operand_valid = 1'b0;
        nx.bus_rdata = CONST_0;
        // A halted core only accepts interrupt entry commands; the halt flag stays set
        take = cmd_valid && (st.state == CRF_IDLE)
            && (!st.sr[SR_HALT] || (cmd_op == CRF_IRQ));
        if (take) begin
            case (cmd_op)
                CRF_ADVANCE: nx.pc = st.pc + {16'h0000, adv};
                CRF_JUMP16: nx.pc = {4'h0, cmd_data[15:1], 1'b0};
                CRF_JUMP20: nx.pc = {cmd_data[19:1], 1'b0};
                CRF_CALL16: begin
                    nx.sp = st.sp - STEP_WORD;
                    nx.push_valid = 1'b1;
                    nx.push_addr = st.sp - STEP_WORD;
                    nx.push_data = {4'h0, st.pc[15:0]};
                    nx.push_wide = 1'b0;
                    nx.pc = {4'h0, cmd_data[15:1], 1'b0};
                end
                CRF_CALL20: begin
                    nx.sp = st.sp - STEP_ADDR;
                    nx.push_valid = 1'b1;
                    nx.push_addr = st.sp - STEP_ADDR;
                    nx.push_data = st.pc;
                    nx.push_wide = 1'b1;
                    nx.pc = {cmd_data[19:1], 1'b0};
                end
                CRF_EXIT16: begin
                    nx.pc = {4'h0, cmd_data[15:1], 1'b0};
                    nx.sp = st.sp + STEP_WORD;
                end
                CRF_EXIT20: begin
                    nx.pc = {cmd_data[19:1], 1'b0};
                    nx.sp = st.sp + STEP_ADDR;
                end
                CRF_IRQ: begin
                    // First word: low counter bits; flags word follows
                    nx.irq_pc = st.pc;
                    nx.irq_vec = cmd_data;
                    nx.sp = st.sp - STEP_WORD;
                    nx.push_valid = 1'b1;
                    nx.push_addr = st.sp - STEP_WORD;
                    nx.push_data = {4'h0, st.pc[15:0]};
                    nx.push_wide = 1'b0;
                    nx.state = CRF_IRQ_SR;
                end
                CRF_IEXIT: begin
                    nx.sr = {4'h0, cmd_aux[11:0]};
                    nx.pc = {cmd_aux[15:12], cmd_data[15:1], 1'b0};
                    nx.sp = st.sp + STEP_ADDR;
                end
                CRF_PUSH: begin
                    nx.sp = st.sp - stack_step;
                    nx.push_valid = 1'b1;
                    nx.push_addr = st.sp - stack_step;
                    // Pushing the stack register stores its value before the decrement
                    nx.push_data = (cmd_dst == REG_SP) ? width_clear(cmd_width, st.sp)
                        : dst_val;
                    nx.push_wide = (cmd_width == CRF_ADDR);
                end
                CRF_POP: begin
                    do_write = 1'b1;
                    if (cmd_dst != REG_SP) begin
                        nx.sp = st.sp + stack_step;
                    end
                end
                CRF_WRITE: do_write = 1'b1;
                CRF_SIGN_WIDEN: begin
                    do_write = 1'b1;
                    dst_val = {{12{cmd_data[7]}}, cmd_data[7:0]};
                end
                default: ;
            endcase
        end
        if (st.state == CRF_IRQ_SR) begin
            nx.sp = st.sp - STEP_WORD;
            nx.push_valid = 1'b1;
            nx.push_addr = st.sp - STEP_WORD;
            nx.push_data = {4'h0, st.irq_pc[19:16], st.sr[11:0]};
            nx.push_wide = 1'b0;
            nx.pc = {4'h0, st.irq_vec[15:1], 1'b0};
            nx.state = CRF_IDLE;
        end
        // ALU flags first, so an explicit write into the flags register wins
        if (alu_en && take && (cmd_op != CRF_IEXIT)) begin
            nx.sr[SR_C] = alu_carry;
            nx.sr[SR_Z] = (width_clear(alu_width, alu_res) == CONST_0);
            nx.sr[SR_N] = sres;
            nx.sr[SR_V] = alu_sub ? ((sa != sb) && (sres != sa))
                : ((sa == sb) && (sres != sa));
        end
        mem_if.we = 1'b0;
        mem_if.waddr = cmd_dst;
        mem_if.wdata = dst_val;
        mem_if.raddr = src_reg;
        if (do_write) begin
            case (cmd_dst)
                REG_PC: nx.pc = {dst_val[19:1], 1'b0};
                REG_SP: nx.sp = {dst_val[19:1], 1'b0};
                REG_SR: nx.sr = dst_val[15:0];
                REG_CG: ;
                default: mem_if.we = 1'b1;
            endcase
        end
        // Software port: writes override the datapath in the same cycle
        if (bus_wr) begin
            case (bus_addr)
                BUS_PC: nx.pc = {bus_wdata[19:1], 1'b0};
                BUS_SP: nx.sp = {bus_wdata[19:1], 1'b0};
                BUS_SR: nx.sr = bus_wdata[15:0];
                default: ;
            endcase
        end
        if (bus_rd) begin
            case (bus_addr)
                BUS_PC: nx.bus_rdata = st.pc;
                BUS_SP: nx.bus_rdata = st.sp;
                BUS_SR: nx.bus_rdata = {4'h0, st.sr};
                BUS_STAT: begin
                    nx.bus_rdata[STAT_BUSY] = st.busy;
                    nx.bus_rdata[STAT_HALT] = st.core_halt;
                    nx.bus_rdata[STAT_IRQ] = st.irq_accept;
                end
                default: ;
            endcase
        end
        // Operand pipeline: capture the request, then select once the array answers
        nx.s1_valid = src_rd;
        nx.s1_reg = src_reg;
        nx.s1_mode = source_mode_field;
        nx.s1_width = src_width;
        case (st.s1_reg)
            REG_PC: opv = st.pc;
            REG_SP: opv = st.sp;
            REG_SR: opv = {4'h0, st.sr};
            default: opv = mem_if.rdata;
        endcase
        if (st.s1_valid) begin
            nx.operand_valid = 1'b1;
            nx.operand_const = 1'b0;
            nx.operand_illegal = 1'b0;
            nx.operand = (st.s1_mode == 2'h0) ? width_clear(st.s1_width, opv) : opv;
            if (st.s1_reg == REG_SR) begin
                nx.operand_const = (st.s1_mode != 2'h0);
                case (st.s1_mode)
                    2'h0: nx.operand_illegal = (st.s1_width != CRF_WORD);
                    2'h1: nx.operand = CONST_0;
                    2'h2: nx.operand = CONST_4;
                    default: nx.operand = CONST_8;
                endcase
            end else if (st.s1_reg == REG_CG) begin
                nx.operand_const = 1'b1;
                case (st.s1_mode)
                    2'h0: nx.operand = CONST_0;
                    2'h1: nx.operand = CONST_1;
                    2'h2: nx.operand = CONST_2;
                    default: nx.operand = width_clear(st.s1_width, CONST_ONES);
                endcase
            end
        end
        nx.busy = (nx.state != CRF_IDLE);
        nx.irq_accept = irq_req && st.sr[SR_GIE];
        nx.vec_addr = VEC_TOP - {13'h0000, irq_line, 1'b0};
        nx.core_halt = nx.sr[SR_HALT];
        nx.loop_off = nx.sr[SR_LOOP];
        nx.crystal_off = nx.sr[SR_XTAL] && !crystal_in_use;
        nx.dco_off = nx.sr[SR_DCO] && !dco_in_use;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.pc <= PC_RESET;
            st.sp <= SP_RESET;
            st.sr <= SR_RESET;
            st.state <= CRF_IDLE;
        end else begin
            st <= nx;
        end
    end

    assign bus_rdata = st.bus_rdata;
    assign pc_out = st.pc;
    assign sp_out = st.sp;
    assign flags_register = st.sr;
    assign busy = st.busy;
    assign operand = st.operand;
    assign operand_valid = st.operand_valid;
    assign operand_const = st.operand_const;
    assign operand_illegal = st.operand_illegal;
    assign push_valid = st.push_valid;
    assign push_addr = st.push_addr;
    assign push_data = st.push_data;
    assign push_wide = st.push_wide;
    assign irq_accept = st.irq_accept;
    assign vec_addr = st.vec_addr;
    assign core_halt = st.core_halt;
    assign loop_control_disable = st.loop_off;
    assign crystal_disable = st.crystal_off;
    assign digital_oscillator_disable = st.dco_off;

    ////////////////////////////////////////////////////////////////////////
    property p_advance;
        @(posedge sys_clk) disable iff (!rst_n)
        (take && cmd_op == CRF_ADVANCE && !bus_wr && cmd_len == 2'h3)
            |=> (st.pc == $past(st.pc) + 20'h0_0008);
    endproperty
    a_advance: assert property (p_advance) else $error("counter step wrong");

    property p_short_call;
        @(posedge sys_clk) disable iff (!rst_n)
        (take && cmd_op == CRF_CALL16 && !bus_wr)
            |=> (push_valid && !push_wide && push_data[19:16] == 4'h0
                && pc_out[19:16] == 4'h0 && sp_out == $past(st.sp) - 20'h0_0002);
    endproperty
    a_short_call: assert property (p_short_call) else $error("short call wrong");

    property p_long_exit;
        @(posedge sys_clk) disable iff (!rst_n)
        (take && cmd_op == CRF_EXIT20 && !bus_wr)
            |=> (sp_out == $past(st.sp) + 20'h0_0004 && pc_out[19:1] == $past(cmd_data[19:1]));
    endproperty
    a_long_exit: assert property (p_long_exit) else $error("long return wrong");

    sequence s_irq_start;
        take && cmd_op == CRF_IRQ && !bus_wr;
    endsequence
    sequence s_irq_pushes;
        (push_valid && push_data[15:0] == $past(st.pc[15:0]))
        ##1 (push_valid && push_data[15:12] == $past(st.pc[19:16], 2)
            && pc_out[19:16] == 4'h0 && !busy);
    endsequence
    property p_irq_entry;
        @(posedge sys_clk) disable iff (!rst_n)
        s_irq_start |=> s_irq_pushes;
    endproperty
    a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry wrong");

    property p_sp_even;
        @(posedge sys_clk) disable iff (!rst_n)
        !sp_out[0] && !pc_out[0];
    endproperty
    a_sp_even: assert property (p_sp_even) else $error("odd stack or counter");

    property p_pop_sp;
        @(posedge sys_clk) disable iff (!rst_n)
        (take && cmd_op == CRF_POP && cmd_dst == REG_SP && cmd_width == CRF_ADDR && !bus_wr)
            |=> (sp_out == {$past(cmd_data[19:1]), 1'b0});
    endproperty
    a_pop_sp: assert property (p_pop_sp) else $error("pop into stack wrong");

    property p_gie;
        @(posedge sys_clk) disable iff (!rst_n)
        irq_accept |-> ($past(irq_req) && $past(st.sr[SR_GIE]));
    endproperty
    a_gie: assert property (p_gie) else $error("interrupt taken while masked");

    property p_const_ones;
        @(posedge sys_clk) disable iff (!rst_n)
        (src_rd && src_reg == REG_CG && source_mode_field == 2'h3 && src_width == CRF_WORD)
            |=> ##1 (operand_valid && operand_const && operand == 20'h0_FFFF);
    endproperty
    a_const_ones: assert property (p_const_ones) else $error("constant wrong");

    property p_byte_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        (mem_if.we && take && cmd_op == CRF_WRITE && cmd_width == CRF_BYTE)
            |-> (mem_if.wdata[19:8] == 12'h000);
    endproperty
    a_byte_clear: assert property (p_byte_clear) else $error("byte write not cleared");
endmodule
`default_nettype wire

// file: design/crf_core_end.sv
// Spare source unit of the core register file; holds no logic

// file: tb/crf_partner.sv
// Stack side of the memory bus: keeps the last word pushed by the core
`timescale 1ns/10ps
`default_nettype none
module crf_partner (
    input wire logic sys_clk,
    input wire logic push_valid,
    input wire logic [19:0] push_addr,
    input wire logic [19:0] push_data,
    input wire logic push_wide,
    output logic [19:0] last_addr,
    output logic [19:0] last_data,
    output logic last_wide
);
    // Push strobe stands one cycle per push (two back to back on interrupt entry), so each is taken on its edge
    always @(posedge sys_clk) begin
        if (push_valid) begin
            last_addr <= push_addr;
            last_data <= push_data;
            last_wide <= push_wide;
        end
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the core register file
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
$display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module testbench;
    import crf_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, alu_en = 1'b0, alu_sub = 1'b0;
    logic alu_carry = 1'b0, src_rd = 1'b0, irq_req = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic crystal_in_use = 1'b0, dco_in_use = 1'b0;
    crf_op_t cmd_op = CRF_NOP;
    crf_width_t cmd_width = CRF_WORD, alu_width = CRF_WORD, src_width = CRF_WORD;
    logic [3:0] cmd_dst = 4'h0, src_reg = 4'h0, bus_addr = 4'h0;
    logic [1:0] cmd_len = 2'h0, source_mode_field = 2'h0;
    logic [19:0] cmd_data = 20'h0_0000, alu_a = 20'h0_0000, alu_b = 20'h0_0000;
    logic [19:0] alu_res = 20'h0_0000, bus_wdata = 20'h0_0000;
    logic [15:0] cmd_aux = 16'h0000;
    logic [5:0] irq_line = 6'h00;
    logic [19:0] bus_rdata, pc_out, sp_out, operand, push_addr, push_data, vec_addr;
    logic [19:0] last_addr, last_data;
    logic [15:0] flags_register;
    logic busy, operand_valid, operand_const, operand_illegal, push_valid, push_wide;
    logic irq_accept, core_halt, loop_control_disable, crystal_disable;
    logic digital_oscillator_disable, last_wide;
    int n_fail = 0, checks_done = 0, cycles = 0;
    crf_core i_crf_core (.sys_clk, .nrst, .cmd_valid, .cmd_op, .cmd_width, .cmd_dst, .cmd_len,
        .cmd_data, .cmd_aux, .alu_en, .alu_sub, .alu_width, .alu_a, .alu_b, .alu_res,
        .alu_carry, .src_rd, .src_reg, .source_mode_field, .src_width, .irq_req, .irq_line,
        .crystal_in_use, .dco_in_use, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .pc_out, .sp_out, .flags_register, .busy, .operand, .operand_valid, .operand_const,
        .operand_illegal, .push_valid, .push_addr, .push_data, .push_wide, .irq_accept,
        .vec_addr, .core_halt, .loop_control_disable, .crystal_disable,
        .digital_oscillator_disable);
    crf_partner i_crf_partner (.sys_clk, .push_valid, .push_addr, .push_data, .push_wide,
        .last_addr, .last_data, .last_wide);
    always #20 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmd(crf_op_t op, crf_width_t w, logic [3:0] d, logic [19:0] v);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_width <= w;
        cmd_dst <= d;
        cmd_data <= v;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic bwr(logic [3:0] a, logic [19:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic brd(logic [3:0] a, logic [19:0] e);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        `CHK(bus_rdata, e)
    endtask
    // Operand answer comes two cycles after the request edge
    task automatic opr(logic [3:0] r, logic [1:0] m, crf_width_t w, logic [19:0] e);
        @(posedge sys_clk);
        src_rd <= 1'b1;
        src_reg <= r;
        source_mode_field <= m;
        src_width <= w;
        @(posedge sys_clk);
        src_rd <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK({operand_valid, operand}, {1'b1, e})
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_regs();
        brd(BUS_PC, PC_RESET);
        brd(BUS_SP, SP_RESET);
        bwr(4'h9, 20'h1_2345);
        brd(4'h9, 20'h0_0000);
    endtask
    task automatic s_calls();
        bwr(BUS_SP, 20'h0_0400);
        cmd(CRF_JUMP20, CRF_ADDR, REG_PC, 20'h1_2346);
        `CHK(pc_out, 20'h1_2346)
        cmd(CRF_CALL16, CRF_WORD, REG_PC, 20'h5_5678);
        `CHK({pc_out, sp_out, last_data}, {20'h0_5678, 20'h0_03FE, 20'h0_2346})
        cmd(CRF_CALL20, CRF_ADDR, REG_PC, 20'hA_BCDE);
        `CHK({last_wide, last_addr, pc_out}, {1'b1, 20'h0_03FA, 20'hA_BCDE})
        `CHK(last_data, 20'h0_5678)
        cmd(CRF_EXIT20, CRF_ADDR, REG_PC, 20'h0_5678);
        `CHK({pc_out, sp_out}, {20'h0_5678, 20'h0_03FE})
        cmd(CRF_EXIT16, CRF_WORD, REG_PC, 20'hF_2346);
        `CHK({pc_out, sp_out}, {20'h0_2346, 20'h0_0400})
        cmd(CRF_WRITE, CRF_WORD, REG_PC, 20'hF_1230);
        `CHK(pc_out, 20'h0_1230)
        cmd(CRF_PUSH, CRF_WORD, REG_SP, 20'h0_0000);
        `CHK({last_data, sp_out}, {20'h0_0400, 20'h0_03FE})
        cmd(CRF_POP, CRF_ADDR, REG_SP, 20'h0_0500);
        `CHK(sp_out, 20'h0_0500)
        cmd_len <= 2'h3;
        cmd(CRF_ADVANCE, CRF_WORD, REG_PC, 20'h0_0000);
        `CHK(pc_out, 20'h0_1238)
    endtask
    task automatic s_data();
        logic [19:0] cg[4];
        cg = '{CONST_0, CONST_1, CONST_2, 20'h0_FFFF};
        cmd(CRF_WRITE, CRF_BYTE, 4'h4, 20'hF_FFFF);
        opr(4'h4, 2'h0, CRF_ADDR, 20'h0_00FF);
        cmd(CRF_SIGN_WIDEN, CRF_WORD, 4'h6, 20'h0_0080);
        opr(4'h6, 2'h0, CRF_ADDR, 20'hF_FF80);
        cmd(CRF_WRITE, CRF_WORD, REG_CG, 20'h0_0123);
        for (int m = 0; m < 4; m++) begin
            opr(REG_CG, m[1:0], CRF_WORD, cg[m]);
        end
        opr(REG_SR, 2'h1, CRF_WORD, CONST_0);
        opr(REG_SR, 2'h2, CRF_WORD, CONST_4);
        opr(REG_SR, 2'h3, CRF_WORD, CONST_8);
        `CHK({operand_illegal, operand_const}, 2'b01)
        opr(REG_SR, 2'h0, CRF_BYTE, CONST_0);
        `CHK({operand_illegal, operand_const}, 2'b10)
    endtask
    task automatic s_irq();
        bwr(BUS_SR, 20'h0_0008);
        cmd(CRF_JUMP20, CRF_ADDR, REG_PC, 20'h3_0010);
        irq_line <= 6'h03;
        irq_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK({irq_accept, vec_addr}, {1'b1, 20'h0_FFF8})
        cmd(CRF_IRQ, CRF_WORD, REG_PC, 20'h1_4444);
        `CHK({last_data, last_addr}, {20'h0_0010, 20'h0_04FE})
        // Flags word is the second push, one cycle behind the counter word
        @(posedge sys_clk);
        #1;
        `CHK({last_data, last_addr}, {20'h0_3008, 20'h0_04FC})
        `CHK({busy, pc_out}, {1'b0, 20'h0_4444})
        cmd_aux <= 16'h3008;
        cmd(CRF_IEXIT, CRF_WORD, REG_PC, 20'h0_0010);
        `CHK(pc_out, 20'h3_0010)
        bwr(BUS_SR, 20'h0_0000);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(irq_accept, 1'b0)
        irq_req <= 1'b0;
    endtask
    task automatic s_flags();
        alu_en <= 1'b1;
        alu_a <= 20'h0_7FFF;
        alu_b <= 20'h0_0001;
        alu_res <= 20'h0_8000;
        cmd(CRF_NOP, CRF_WORD, REG_PC, 20'h0_0000);
        `CHK(flags_register, 16'h0104)
        alu_a <= 20'h0_FFFF;
        alu_res <= 20'h0_0000;
        alu_carry <= 1'b1;
        cmd(CRF_NOP, CRF_WORD, REG_PC, 20'h0_0000);
        `CHK(flags_register, 16'h0003)
        alu_en <= 1'b0;
        crystal_in_use <= 1'b1;
        bwr(BUS_SR, 20'h0_00F0);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK({core_halt, loop_control_disable}, 2'b11)
        `CHK({crystal_disable, digital_oscillator_disable}, 2'b01)
        brd(BUS_STAT, 20'h0_0002);
        // A halted core ignores every command but interrupt entry
        cmd(CRF_JUMP20, CRF_ADDR, REG_PC, 20'h0_0100);
        `CHK(pc_out, 20'h3_0010)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Whole run needs about 120 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        s_regs();
        s_calls();
        s_data();
        s_irq();
        s_flags();
        finish_test();
    end
endmodule
`default_nettype wire
